// ### src/uart_addr_consts.svh
// Constants for the address-detect receiver and its remote sender.
// Assumes inclusion by bare name from both ends and the bench.
`ifndef UART_ADDR_CONSTS_SVH
`define UART_ADDR_CONSTS_SVH

`define OFS_PERIPHERAL_IRQ_FLAGS      8'h0c
`define OFS_RECEIVE_STATUS_CONTROL    8'h18
`define OFS_RECEIVE_DATA_BUFFER       8'h1a
`define OFS_PERIPHERAL_IRQ_ENABLES    8'h8c
`define OFS_TRANSMIT_STATUS_CONTROL   8'h98
`define OFS_BAUD_DIVISOR              8'h99

`define RST_PERIPHERAL_IRQ_FLAGS      8'h00
`define RST_RECEIVE_STATUS_CONTROL    8'h00
`define RST_RECEIVE_DATA_BUFFER       8'h00
`define RST_PERIPHERAL_IRQ_ENABLES    8'h00
`define RST_TRANSMIT_STATUS_CONTROL   8'h02
`define RST_BAUD_DIVISOR              8'h00

// receive_status_control fields
`define BIT_SERIAL_PORT_ENABLE        7
`define BIT_NINE_BIT_SELECT           6
`define BIT_SINGLE_RECEIVE_ENABLE     5
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_ADDRESS_DETECT_ENABLE     3
`define BIT_FRAMING_ERROR_FLAG        2
`define BIT_OVERRUN_ERROR_FLAG        1
`define BIT_NINTH_BIT_VALUE           0
// transmit_status_control fields
`define BIT_CLOCKED_MODE_SELECT       4
`define BIT_HIGH_SPEED_BAUD           2
// irq flag and enable fields
`define BIT_RECEIVE_FLAG              5

// Bit period is divisor+1 times this many clocks
`define PRESCALE_LOW_SPEED            64
`define PRESCALE_HIGH_SPEED           16
`define PRESCALE_W                    7

`endif

// ### src/uart_addr_if.sv
// Serial line between the receiving station and the remote master.
// Assumes both ends share i_sys_clk; the line idles high.
`timescale 1ns/100ps
interface uart_addr_if;
    logic serial_line;
    logic rx_pin_oe;
    logic tx_pin_oe;

    modport station (
        input  serial_line,
        output rx_pin_oe,
        output tx_pin_oe
    );
    modport master (
        output serial_line
    );
endinterface : uart_addr_if

// ### src/uart_addr_pkg.sv
// Types shared by the receiver and the sender.
// Assumes the constants header is visible on the include path.
package uart_addr_pkg;
    typedef enum {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;

    typedef enum {
        TX_IDLE,
        TX_BITS
    } tx_state_t;
endpackage : uart_addr_pkg

// ### src/uart_addr_rx.sv
// Receiving station: asynchronous receiver with nine-bit address filter.
// Assumes the serial line is synchronous to i_sys_clk and idles high.
// Function
// - Nine-bit mode stores ninth bit value
// - Detection needs address-detect and nine-bit set
// - Load buffer; flag only if bit8 one
// - Master sends ninth bit one for addresses
// - Data characters not loaded, no flag
// - Ignored character overwritten by next one
// - Address-detect ignored in eight-bit mode
// - Detection off: accept all, pass ninth bit
// - Continuous-receive enable starts reception
// - Addressed software clears address-detect and flag
// - Flag on load; interrupt needs enable
// - Clearing continuous-receive clears overrun
// - Baud divisor sets rate; high-speed option
// - Software selects async mode, enables port
// - Pins input; peripheral never drives them
// - Data read returns low eight bits
// - Single-receive enable also permits reception
`timescale 1ns/100ps
`include "uart_addr_consts.svh"
module uart_addr_rx (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    input  wire logic [7:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic [7:0]         o_rdata,
    output logic               o_irq,
    uart_addr_if.station       line
);
    typedef struct packed {
        uart_addr_pkg::rx_state_t st;
        logic [7:0]  receive_status_control;
        logic [7:0]  transmit_status_control;
        logic [7:0]  baud;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [7:0]  data;
        logic        full;
        logic [8:0]  shift;
        logic [3:0]  bits;
        logic [15:0] tick;
        logic [7:0]  rdata;
    } rx_t;

    rx_t s_r;
    rx_t s_nxt;
    logic [15:0] period;
    logic        en_rx;
    logic [7:0]  status;

    function automatic logic [15:0] bit_period(input logic [7:0] div,
                                               input logic hs);
        logic [15:0] pre;
        pre = hs ? 16'(`PRESCALE_HIGH_SPEED) : 16'(`PRESCALE_LOW_SPEED);
        bit_period = 16'(({8'h00, div} + 16'h0001) * pre);
    endfunction : bit_period

    // Peripheral never drives either pin in async receive
    assign line.rx_pin_oe = 1'b0;
    assign line.tx_pin_oe = 1'b0;
    assign status = s_r.receive_status_control;
    assign period = bit_period(s_r.baud,
                        s_r.transmit_status_control[`BIT_HIGH_SPEED_BAUD]);
    assign en_rx = status[`BIT_SERIAL_PORT_ENABLE]
                 & (status[`BIT_CONTINUOUS_RECEIVE_ENABLE]
                  | status[`BIT_SINGLE_RECEIVE_ENABLE]);
    assign o_rdata = s_r.rdata;
    // Level output; drops when the flag is written with a one or its enable is cleared
    assign o_irq = |(s_r.flags & s_r.enables);

    always_comb begin
        logic       nine;
        logic       adet;
        logic       stop_ok;
        logic [7:0] status_nxt;
        nine    = status[`BIT_NINE_BIT_SELECT];
        // Address detect only counts in nine-bit mode
        adet    = nine & status[`BIT_ADDRESS_DETECT_ENABLE];
        stop_ok = line.serial_line;
        status_nxt = status;
        s_nxt   = s_r;
        s_nxt.rdata = 8'h00;

        // Register port; writes before hardware events so set wins
        if (i_wr) begin
            case (i_addr)
                `OFS_RECEIVE_STATUS_CONTROL: begin
                    status_nxt[7:3] = i_wdata[7:3];
                    if (!i_wdata[`BIT_CONTINUOUS_RECEIVE_ENABLE])
                        status_nxt[`BIT_OVERRUN_ERROR_FLAG] = 1'b0;
                end
                `OFS_TRANSMIT_STATUS_CONTROL: begin
                    // Clocked-mode bit kept; bits 3 and 0 read 0, bit 1 one
                    s_nxt.transmit_status_control =
                        {i_wdata[7:4], 1'b0, i_wdata[2], 2'b10};
                end
                `OFS_BAUD_DIVISOR:           s_nxt.baud = i_wdata;
                `OFS_PERIPHERAL_IRQ_ENABLES: s_nxt.enables = i_wdata & 8'hf7;
                `OFS_PERIPHERAL_IRQ_FLAGS:   s_nxt.flags = s_r.flags
                                                & ~i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `OFS_RECEIVE_STATUS_CONTROL:  s_nxt.rdata = status;
                `OFS_TRANSMIT_STATUS_CONTROL:
                    s_nxt.rdata = s_r.transmit_status_control;
                `OFS_BAUD_DIVISOR:            s_nxt.rdata = s_r.baud;
                `OFS_PERIPHERAL_IRQ_ENABLES:  s_nxt.rdata = s_r.enables;
                `OFS_PERIPHERAL_IRQ_FLAGS:    s_nxt.rdata = s_r.flags;
                `OFS_RECEIVE_DATA_BUFFER: begin
                    s_nxt.rdata = s_r.data;
                    s_nxt.full  = 1'b0;
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // Start is checked again at mid-bit so a glitch is dropped
        case (s_r.st)
            uart_addr_pkg::RX_IDLE: begin
                if (en_rx && !line.serial_line) begin
                    s_nxt.tick = {1'b0, period[15:1]};
                    s_nxt.st   = uart_addr_pkg::RX_START;
                end
            end
            uart_addr_pkg::RX_START: begin
                if (s_r.tick == 16'd0) begin
                    s_nxt.tick = period - 16'd1;
                    s_nxt.bits = nine ? 4'd9 : 4'd8;
                    s_nxt.st   = line.serial_line
                               ? uart_addr_pkg::RX_IDLE
                               : uart_addr_pkg::RX_DATA;
                end else begin
                    s_nxt.tick = s_r.tick - 16'd1;
                end
            end
            uart_addr_pkg::RX_DATA: begin
                if (s_r.tick == 16'd0) begin
                    // New character overwrites whatever was left
                    s_nxt.shift = nine
                        ? {line.serial_line, s_r.shift[8:1]}
                        : {1'b0, line.serial_line, s_r.shift[7:1]};
                    s_nxt.bits = s_r.bits - 4'd1;
                    s_nxt.tick = period - 16'd1;
                    if (s_r.bits == 4'd1)
                        s_nxt.st = uart_addr_pkg::RX_STOP;
                end else begin
                    s_nxt.tick = s_r.tick - 16'd1;
                end
            end
            uart_addr_pkg::RX_STOP: begin
                if (s_r.tick == 16'd0) begin
                    s_nxt.st = uart_addr_pkg::RX_IDLE;
                    // Single-receive arms one character only
                    if (!status[`BIT_CONTINUOUS_RECEIVE_ENABLE])
                        status_nxt[`BIT_SINGLE_RECEIVE_ENABLE] = 1'b0;
                    if (adet && !s_r.shift[8]) begin
                        // Data character dropped while filtering
                    end else if (s_r.full) begin
                        // Old byte kept even if read in this cycle
                        status_nxt[`BIT_OVERRUN_ERROR_FLAG] = 1'b1;
                    end else begin
                        // Load and flag; bit 8 passes through
                        s_nxt.data = s_r.shift[7:0];
                        s_nxt.full = 1'b1;
                        status_nxt[`BIT_NINTH_BIT_VALUE] =
                            nine & s_r.shift[8];
                        status_nxt[`BIT_FRAMING_ERROR_FLAG] =
                            !stop_ok;
                        s_nxt.flags[`BIT_RECEIVE_FLAG] = 1'b1;
                    end
                end else begin
                    s_nxt.tick = s_r.tick - 16'd1;
                end
            end
            default: s_nxt.st = uart_addr_pkg::RX_IDLE;
        endcase
        s_nxt.receive_status_control = status_nxt;
    end

    // Clock enable low freezes every field, read data too
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r.st      <= uart_addr_pkg::RX_IDLE;
            s_r.receive_status_control  <= `RST_RECEIVE_STATUS_CONTROL;
            s_r.transmit_status_control <= `RST_TRANSMIT_STATUS_CONTROL;
            s_r.baud    <= `RST_BAUD_DIVISOR;
            s_r.flags   <= `RST_PERIPHERAL_IRQ_FLAGS;
            s_r.enables <= `RST_PERIPHERAL_IRQ_ENABLES;
            s_r.data    <= `RST_RECEIVE_DATA_BUFFER;
            s_r.full    <= 1'b0;
            s_r.shift   <= 9'h000;
            s_r.bits    <= 4'd0;
            s_r.tick    <= 16'd0;
            s_r.rdata   <= 8'h00;
        end else if (i_clk_en) begin
            s_r <= s_nxt;
        end
    end
endmodule : uart_addr_rx

// ### src/uart_master_tx.sv
// Remote master sender: frames of start, 8 data, ninth bit, stop.
// Assumes a one-cycle send strobe accepted only while o_busy is low.
`timescale 1ns/100ps
`include "uart_addr_consts.svh"
module uart_master_tx #(
    parameter int DIV = 0
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    input  wire logic          i_high_speed,
    input  wire logic          i_send,
    input  wire logic [8:0]    i_char,
    output logic               o_busy,
    uart_addr_if.master        line
);
    typedef struct packed {
        uart_addr_pkg::tx_state_t st;
        logic [10:0] shift;
        logic [3:0]  bits;
        logic [15:0] tick;
        logic        line;
    } tx_t;

    tx_t s_r;
    tx_t s_nxt;
    logic [15:0] period;

    assign period = 16'((DIV + 1) * (i_high_speed ? `PRESCALE_HIGH_SPEED
                                                  : `PRESCALE_LOW_SPEED));
    assign o_busy = (s_r.st != uart_addr_pkg::TX_IDLE);
    assign line.serial_line = s_r.line;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            uart_addr_pkg::TX_IDLE: begin
                s_nxt.line = 1'b1;
                if (i_send) begin
                    // Ninth bit one marks an address
                    s_nxt.shift = {1'b1, i_char, 1'b0};
                    s_nxt.bits  = 4'd11;
                    s_nxt.tick  = 16'd0;
                    s_nxt.st    = uart_addr_pkg::TX_BITS;
                end
            end
            uart_addr_pkg::TX_BITS: begin
                if (s_r.tick == 16'd0) begin
                    if (s_r.bits == 4'd0) begin
                        s_nxt.st   = uart_addr_pkg::TX_IDLE;
                        s_nxt.line = 1'b1;
                    end else begin
                        s_nxt.line  = s_r.shift[0];
                        s_nxt.shift = {1'b1, s_r.shift[10:1]};
                        s_nxt.bits  = s_r.bits - 4'd1;
                        s_nxt.tick  = period - 16'd1;
                    end
                end else begin
                    s_nxt.tick = s_r.tick - 16'd1;
                end
            end
            default: s_nxt.st = uart_addr_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r.st    <= uart_addr_pkg::TX_IDLE;
            s_r.shift <= '1;
            s_r.bits  <= 4'd0;
            s_r.tick  <= 16'd0;
            s_r.line  <= 1'b1;
        end else if (i_clk_en) begin
            s_r <= s_nxt;
        end
    end
endmodule : uart_master_tx

// ### test/test_uart_rx_address_detect.sv
// Bench: the sender drives the address-detect receiver over the line.
// Assumes 20 MHz clock, divisor 0 and high-speed prescale on both ends.
`timescale 1ns/100ps
`include "uart_addr_consts.svh"
module test_uart_rx_address_detect;
    localparam logic [7:0] A_FLG = `OFS_PERIPHERAL_IRQ_FLAGS;
    localparam logic [7:0] A_RCS = `OFS_RECEIVE_STATUS_CONTROL;
    localparam logic [7:0] A_DAT = `OFS_RECEIVE_DATA_BUFFER;
    localparam logic [7:0] A_ENA = `OFS_PERIPHERAL_IRQ_ENABLES;
    localparam logic [7:0] A_TXS = `OFS_TRANSMIT_STATUS_CONTROL;
    localparam logic [7:0] A_BAU = `OFS_BAUD_DIVISOR;
    logic       i_sys_clk       = 1'b0;
    logic       i_rst_n         = 1'b0;
    logic       clk_en          = 1'b1;
    logic [7:0] addr            = 8'h00;
    logic [7:0] wdata           = 8'h00;
    logic       wr              = 1'b0;
    logic       rd              = 1'b0;
    logic       send            = 1'b0;
    logic [8:0] char_in         = 9'h000;
    logic [7:0] rdata;
    logic       irq;
    logic       busy;
    int         error_cnt       = 0;
    int         samples_checked = 0;

    uart_addr_if line_if ();
    uart_addr_rx i_uart_addr_rx (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .line(line_if.station));
    uart_master_tx #(.DIV(0)) i_uart_master_tx (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_high_speed(1'b1),
        .i_send(send), .i_char(char_in), .o_busy(busy),
        .line(line_if.master));
    uart_addr_rx_asserts chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .serial_line(line_if.serial_line), .rx_pin_oe(line_if.rx_pin_oe),
        .tx_pin_oe(line_if.tx_pin_oe));

    always #25 i_sys_clk = ~i_sys_clk;

    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] got);
        samples_checked++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] e, input string what);
        @(posedge i_sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1 check(what, e & m, rdata & m);
    endtask : reg_chk

    task automatic irq_chk(input logic e);
        #1 check("irq", {7'h00, e}, {7'h00, irq});
    endtask : irq_chk

    task automatic send_char(input logic [8:0] c);
        int n = 0;
        @(posedge i_sys_clk);
        send    <= 1'b1;
        char_in <= c;
        @(posedge i_sys_clk);
        send <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        check("sender done", 8'h00, {7'h00, busy});
        // Receiver flags land mid-stop, before the sender goes idle
        repeat (4) @(posedge i_sys_clk);
    endtask : send_char

    task automatic t_reset;
        reg_chk(A_FLG, 8'hff, `RST_PERIPHERAL_IRQ_FLAGS, "flags");
        reg_chk(A_RCS, 8'hff, `RST_RECEIVE_STATUS_CONTROL, "rcs");
        reg_chk(A_DAT, 8'hff, `RST_RECEIVE_DATA_BUFFER, "data");
        reg_chk(A_ENA, 8'hff, `RST_PERIPHERAL_IRQ_ENABLES, "enables");
        reg_chk(A_TXS, 8'hff, `RST_TRANSMIT_STATUS_CONTROL, "txs");
        reg_chk(A_BAU, 8'hff, `RST_BAUD_DIVISOR, "baud");
        reg_chk(8'h00, 8'hff, 8'h00, "unmapped");
        irq_chk(1'b0);
        reg_wr(A_BAU, 8'h00);
        reg_wr(A_TXS, 8'h0d);
        reg_chk(A_TXS, 8'hff, 8'h06, "txs fixed bits");
        reg_wr(A_ENA, 8'h20);
    endtask : t_reset

    task automatic t_filter;
        reg_wr(A_RCS, 8'hd8);
        send_char(9'h055);
        reg_chk(A_FLG, 8'h20, 8'h00, "data char flag");
        irq_chk(1'b0);
        send_char(9'h066);
        send_char(9'h1a3);
        reg_chk(A_FLG, 8'h20, 8'h20, "address flag");
        irq_chk(1'b1);
        reg_chk(A_RCS, 8'h01, 8'h01, "ninth bit");
        reg_chk(A_DAT, 8'hff, 8'ha3, "address data");
        reg_wr(A_ENA, 8'h00);
        irq_chk(1'b0);
        reg_wr(A_ENA, 8'h20);
        irq_chk(1'b1);
        reg_wr(A_FLG, 8'h20);
        irq_chk(1'b0);
    endtask : t_filter

    task automatic t_pass;
        reg_wr(A_RCS, 8'hd0);
        send_char(9'h03c);
        reg_chk(A_FLG, 8'h20, 8'h20, "data flag");
        reg_chk(A_RCS, 8'h01, 8'h00, "parity zero");
        reg_chk(A_DAT, 8'hff, 8'h3c, "data");
        reg_wr(A_FLG, 8'h20);
        send_char(9'h1c5);
        reg_chk(A_RCS, 8'h01, 8'h01, "parity one");
        reg_chk(A_DAT, 8'hff, 8'hc5, "data");
        reg_wr(A_FLG, 8'h20);
    endtask : t_pass

    // Eight-bit mode: the ninth slot is taken as the stop bit
    task automatic t_eight;
        reg_wr(A_RCS, 8'h98);
        send_char(9'h15a);
        reg_chk(A_FLG, 8'h20, 8'h20, "eight-bit flag");
        reg_chk(A_RCS, 8'h04, 8'h00, "no framing");
        reg_chk(A_DAT, 8'hff, 8'h5a, "eight-bit data");
        reg_wr(A_FLG, 8'h20);
        send_char(9'h0a5);
        reg_chk(A_RCS, 8'h04, 8'h04, "framing error");
        reg_chk(A_DAT, 8'hff, 8'ha5, "framed data");
        reg_wr(A_FLG, 8'h20);
    endtask : t_eight

    task automatic t_overrun;
        reg_wr(A_RCS, 8'hd0);
        send_char(9'h011);
        send_char(9'h022);
        reg_chk(A_RCS, 8'h02, 8'h02, "overrun");
        reg_chk(A_DAT, 8'hff, 8'h11, "kept data");
        reg_wr(A_RCS, 8'hc0);
        reg_chk(A_RCS, 8'h02, 8'h00, "overrun cleared");
        reg_wr(A_FLG, 8'h20);
    endtask : t_overrun

    task automatic t_single;
        send_char(9'h077);
        reg_chk(A_FLG, 8'h20, 8'h00, "receiver off");
        reg_wr(A_RCS, 8'he0);
        send_char(9'h188);
        reg_chk(A_FLG, 8'h20, 8'h20, "single flag");
        reg_chk(A_DAT, 8'hff, 8'h88, "single data");
        reg_chk(A_RCS, 8'h20, 8'h00, "single done");
    endtask : t_single

    // Clock enable low must swallow a register write
    task automatic t_freeze;
        @(posedge i_sys_clk);
        clk_en <= 1'b0;
        reg_wr(A_BAU, 8'h5a);
        clk_en <= 1'b1;
        reg_chk(A_BAU, 8'hff, 8'h00, "frozen baud");
    endtask : t_freeze

    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_filter();
        t_pass();
        t_eight();
        t_overrun();
        t_single();
        t_freeze();
        print_verdict();
    end

    // 11 frames expected; allow ample margin
    initial begin
        #(50 * 20000);
        error_cnt++;
        print_verdict();
    end
endmodule : test_uart_rx_address_detect

// ### test/uart_addr_rx_asserts.sv
// Checker for the serial line joining the sender and the receiver.
// Assumes divisor 0 with high-speed prescale: 16 clocks to a bit.
`timescale 1ns/100ps
module uart_addr_rx_asserts (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic serial_line,
    input  wire logic rx_pin_oe,
    input  wire logic tx_pin_oe
);
    logic       line_r;
    logic       act_r;
    logic [7:0] cnt_r;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // Frame tracker; sample k of a frame lies in bit slot k/16
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_r <= 1'b1;
            act_r  <= 1'b0;
            cnt_r  <= 8'h00;
        end else begin
            line_r <= serial_line;
            if (act_r) begin
                act_r <= (cnt_r != 8'd175);
                cnt_r <= cnt_r + 8'h01;
            end else if (line_r && !serial_line) begin
                act_r <= 1'b1;
                cnt_r <= 8'h01;
            end
        end
    end

    chk_rx_oe_off: assert property (!rx_pin_oe)
        else $error("receive pin output enable raised");
    chk_tx_oe_off: assert property (!tx_pin_oe)
        else $error("transmit pin output enable raised");
    chk_idle_after_reset: assert property (
        $rose(i_rst_n) |-> serial_line)
        else $error("line not idle high after reset");
    chk_start_full: assert property ($fell(serial_line) && !act_r |->
        (!serial_line)[*8] ##1 (!serial_line)[*8])
        else $error("start bit shorter than one bit period");
    chk_bit_hold: assert property (
        act_r && cnt_r[3:0] != 4'h0 |-> serial_line == line_r)
        else $error("line changed inside a bit period");
    chk_stop_high: assert property (
        act_r && cnt_r >= 8'd160 |-> serial_line)
        else $error("stop slot not high");
    chk_stop_span: assert property (act_r && cnt_r == 8'd160 |->
        serial_line[*8] ##1 serial_line[*8])
        else $error("stop bit shorter than one bit period");
    chk_no_stray_low: assert property (!act_r && !serial_line |-> line_r)
        else $error("line low outside a frame");
endmodule : uart_addr_rx_asserts
